// [include/dual_alu_pkg.sv]
package dual_alu_pkg;

  // ----------------------------------------------------------------
  // Operations, options and flags
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_ADDC, OP_SUBB, OP_ADDH, OP_SUBH,
    OP_COMP, OP_MAX, OP_MIN, OP_ABS
  } op_type;

  typedef enum logic [1:0] {
    OPT_NONE, OPT_JUMP, OPT_CIRC, OPT_BREV
  } option_type;

  localparam logic [3:0]  OP_LAST      = 4'h9;
  localparam int          FLAG_ZERO    = 0;
  localparam int          FLAG_NEG     = 1;
  localparam int          FLAG_OVF     = 2;
  localparam int          FLAG_CARRY   = 3;
  localparam logic [31:0] MOST_NEG     = 32'h8000_0000;
  localparam logic [31:0] MAX_POS      = 32'h7FFF_FFFF;
  localparam logic [4:0]  CIRC_IDX_MAX = 5'h03;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_A_LSB    = 4;
  localparam int CMD_B_LSB    = 9;
  localparam int CMD_DST_LSB  = 14;
  localparam int CMD_USE_IMM  = 19;
  localparam int CMD_IMM8     = 20;
  localparam int CMD_OPT_LSB  = 21;
  localparam int CMD_HOLD     = 23;
  localparam int CMD_UNSIGNED = 24;
  localparam int CMD_ALT_DST  = 25;

  // Status word fields
  localparam int STAT_REJECT    = 4;
  localparam int STAT_CAUSE_LSB = 5;
  localparam logic [1:0] CAUSE_CIRC_IDX = 2'h1;
  localparam logic [1:0] CAUSE_OPTION   = 2'h2;
  localparam logic [1:0] CAUSE_UNKNOWN  = 2'h3;

  // ----------------------------------------------------------------
  // Byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [11:0] CMD_OFFSET   = 12'h000;
  localparam logic [11:0] IMM_OFFSET   = 12'h010;
  localparam logic [11:0] STAT_OFFSET  = 12'h020;
  localparam logic [11:0] JUMP_OFFSET  = 12'h030;
  localparam logic [11:0] LAST_OFFSET  = 12'h038;
  localparam logic [11:0] WORD_STRIDE  = 12'h004;
  localparam logic [11:0] BASE_OFFSET  = 12'h040;
  localparam logic [11:0] LEN_OFFSET   = 12'h080;
  localparam logic [11:0] CIRC_STRIDE  = 12'h010;
  localparam logic [11:0] GPR_OFFSET   = 12'h400;
  localparam logic [11:0] GPR_STRIDE   = 12'h080;
  localparam int          GPR_COUNT    = 32;
  localparam int          CIRC_COUNT   = 4;
  localparam int          UNIT_COUNT   = 2;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [3:0]  RESET_FLAGS  = 4'h0;

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  sel);
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merged[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return merged;
  endfunction

endpackage

// [design/int_arith_core.sv]
`timescale 1ns/1ps
`default_nettype none

module int_arith_core (
  input  wire dual_alu_pkg::op_type     op_code,
  input  wire dual_alu_pkg::option_type option_sel,
  input  wire logic                     unsigned_cmp,
  input  wire logic [31:0]              operand_a,
  input  wire logic [31:0]              operand_b,
  input  wire logic                     carry_in,
  input  wire logic [31:0]              circ_base,
  input  wire logic [31:0]              circ_length,
  output logic [31:0]                   result,
  output logic [3:0]                    flags,
  output logic                          writes_dest
);

  // ----------------------------------------------------------------
  // Shared adder: subtract is a plus inverted b plus one
  // ----------------------------------------------------------------
  function automatic logic [31:0] reverse_bits(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  wire        is_sub    = (op_code == dual_alu_pkg::OP_SUB) | (op_code == dual_alu_pkg::OP_SUBB) |
                          (op_code == dual_alu_pkg::OP_SUBH);
  wire        use_carry = (op_code == dual_alu_pkg::OP_ADDC) | (op_code == dual_alu_pkg::OP_SUBB);
  wire [31:0] b_eff     = is_sub ? ~operand_b : operand_b;
  wire        cin       = use_carry ? carry_in : is_sub;           // [RULE10]
  wire [32:0] wide_sum  = {1'b0, operand_a} + {1'b0, b_eff} + {32'h0000_0000, cin};
  wire [31:0] plain_sum = wide_sum[31:0];
  wire        plain_ovf = (operand_a[31] == b_eff[31]) & (plain_sum[31] != operand_a[31]);

  // Halving keeps a 33rd bit so the shift never loses the true sign
  wire [32:0] half_wide = is_sub ? {operand_a[31], operand_a} - {operand_b[31], operand_b}
                                 : {operand_a[31], operand_a} + {operand_b[31], operand_b};
  wire [31:0] half_res  = half_wide[32:1];                          // [RULE11]

  // Circular buffer: wrap once into base .. base+length-1
  wire [31:0] circ_raw  = is_sub ? operand_a - operand_b : operand_a + operand_b;
  wire [31:0] circ_end  = circ_base + circ_length;
  wire [31:0] circ_res  = (circ_raw >= circ_end) ? circ_raw - circ_length :
                          (circ_raw < circ_base) ? circ_raw + circ_length : circ_raw; // [RULE4]

  // Bit-reverse adder: carries run from the msb toward the lsb
  wire [31:0] rev_a     = reverse_bits(operand_a);
  wire [31:0] rev_b     = reverse_bits(operand_b);
  wire [31:0] rev_sum   = is_sub ? rev_a - rev_b : rev_a + rev_b;
  wire [31:0] brev_res  = reverse_bits(rev_sum);                    // [RULE5]

  // Compare, select and magnitude
  wire        equal     = operand_a == operand_b;
  wire        less_s    = $signed(operand_a) < $signed(operand_b);
  wire        less_u    = operand_a < operand_b;
  wire        a_most_ng = operand_a == dual_alu_pkg::MOST_NEG;
  wire [31:0] negated   = ~operand_a + 32'h0000_0001;
  wire [31:0] abs_res   = a_most_ng ? dual_alu_pkg::MAX_POS :
                          (operand_a[31] ? negated : operand_a);    // [RULE15]

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  always_comb begin
    result      = plain_sum;
    writes_dest = 1'b1;
    flags       = 4'h0;
    case (op_code)
      dual_alu_pkg::OP_ADD, dual_alu_pkg::OP_SUB: begin
        if (option_sel == dual_alu_pkg::OPT_CIRC) begin
          result = circ_res;                                        // [RULE8]
        end else if (option_sel == dual_alu_pkg::OPT_BREV) begin
          result = brev_res;                                        // [RULE8]
        end else begin
          result                        = plain_sum;                // [RULE2]
          flags[dual_alu_pkg::FLAG_OVF]   = plain_ovf;              // [RULE9]
          flags[dual_alu_pkg::FLAG_CARRY] = wide_sum[32];           // [RULE9]
        end
        flags[dual_alu_pkg::FLAG_NEG] = result[31];
      end
      dual_alu_pkg::OP_ADDC, dual_alu_pkg::OP_SUBB: begin
        result                          = plain_sum;                // [RULE10]
        flags[dual_alu_pkg::FLAG_NEG]   = plain_sum[31];
        flags[dual_alu_pkg::FLAG_OVF]   = plain_ovf;
        flags[dual_alu_pkg::FLAG_CARRY] = wide_sum[32];
      end
      dual_alu_pkg::OP_ADDH, dual_alu_pkg::OP_SUBH: begin
        result                        = half_res;                   // [RULE19]
        flags[dual_alu_pkg::FLAG_NEG] = half_res[31];
      end
      dual_alu_pkg::OP_COMP: begin
        writes_dest                   = 1'b0;                       // [RULE18]
        flags[dual_alu_pkg::FLAG_NEG] = unsigned_cmp ? less_u : less_s; // [RULE12] [RULE13]
      end
      dual_alu_pkg::OP_MAX: begin
        result                        = less_s ? operand_b : operand_a; // [RULE14]
        flags[dual_alu_pkg::FLAG_NEG] = result[31];
      end
      dual_alu_pkg::OP_MIN: begin
        result                        = less_s ? operand_a : operand_b; // [RULE14]
        flags[dual_alu_pkg::FLAG_NEG] = result[31];
      end
      dual_alu_pkg::OP_ABS: begin
        result                        = abs_res;
        flags[dual_alu_pkg::FLAG_NEG] = operand_a[31];              // [RULE16]
        flags[dual_alu_pkg::FLAG_OVF] = a_most_ng;                  // [RULE15]
      end
      default: begin
        writes_dest = 1'b0;
      end
    endcase
    // Zero flag: equality for compare, all-zero result otherwise
    flags[dual_alu_pkg::FLAG_ZERO] = (op_code == dual_alu_pkg::OP_COMP) ? equal
                                                                        : (result == 32'h0000_0000); // [RULE9]
  end

endmodule

`default_nettype wire

// [design/dual_integer_alu_arith.sv]
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Two independent integer units, each with own registers and flags.
// RULE2: Add or subtract register with register, 8-bit or 32-bit immediate.
// RULE3: Jump option also copies the add or subtract result to jump register.
// RULE4: Circular option allowed only for first operand index 0 to 3.
// RULE5: Bit-reverse option computes through a reversed-carry adder.
// RULE6: The issuer selects at most one of jump, circular, bit-reverse options.
// RULE7: Alternative add or subtract writes a circular base or length register.
// RULE8: Circular or bit-reverse forms never raise overflow and clear carry.
// RULE9: Add/subtract: zero on all-zero result, negative msb, overflow, carry out.
// RULE10: Add with carry and subtract with borrow use the unit carry flag.
// RULE11: Halving uses arithmetic right shift, rounding toward minus infinity.
// RULE12: Compare sets zero on equal, negative on less, clears overflow, carry.
// RULE13: Compare is unsigned with the unsigned option, signed otherwise.
// RULE14: Max and min compare signed, write the chosen operand, clear V and C.
// RULE15: Absolute of most negative gives largest positive and sets overflow.
// RULE16: Absolute: negative follows input msb, carry cleared.
// RULE17: Flag-hold option keeps all four flags while the result is written.
// RULE18: All words are 32 bits; compare writes only the flags.
// RULE19: Halving clears overflow and carry; zero, negative follow the result.
module dual_integer_alu_arith (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  // One access is taken per request; ack follows one cycle later
  wire        bus_req    = wb_cyc_i & wb_stb_i;
  wire        bus_take   = bus_req & ~wb_ack_o;
  wire        write_take = bus_take & wb_we_i;
  wire        read_take  = bus_take & ~wb_we_i;
  wire [11:0] word_adr   = {wb_adr_i[11:2], 2'b00};
  wire        full_word  = wb_sel_i == 4'hF;

  logic [31:0] unit_rdata [dual_alu_pkg::UNIT_COUNT];
  wire  [31:0] read_word = unit_rdata[0] | unit_rdata[1];

  // Registered answer; unmapped reads return zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= dual_alu_pkg::RESET_WORD;
    end else begin
      wb_ack_o <= bus_take;
      if (read_take) begin
        wb_dat_o <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Integer units
  // ----------------------------------------------------------------
  genvar u;
  for (u = 0; u < dual_alu_pkg::UNIT_COUNT; u++) begin : unit_slot   // [RULE1]
    logic [31:0] gpr [dual_alu_pkg::GPR_COUNT];
    logic [31:0] circ_base_regs [dual_alu_pkg::CIRC_COUNT];
    logic [31:0] circ_length_regs [dual_alu_pkg::CIRC_COUNT];
    logic [31:0] computed_jump_reg;
    logic [31:0] imm_value;
    logic [31:0] cmd_word;
    logic [31:0] last_result;
    logic [3:0]  integer_status_reg;
    logic        reject_flag;
    logic [1:0]  reject_cause;

    // Per-unit addresses
    wire [11:0] cmd_adr  = 12'(dual_alu_pkg::CMD_OFFSET  + u * dual_alu_pkg::WORD_STRIDE);
    wire [11:0] imm_adr  = 12'(dual_alu_pkg::IMM_OFFSET  + u * dual_alu_pkg::WORD_STRIDE);
    wire [11:0] stat_adr = 12'(dual_alu_pkg::STAT_OFFSET + u * dual_alu_pkg::WORD_STRIDE);
    wire [11:0] jump_adr = 12'(dual_alu_pkg::JUMP_OFFSET + u * dual_alu_pkg::WORD_STRIDE);
    wire [11:0] last_adr = 12'(dual_alu_pkg::LAST_OFFSET + u * dual_alu_pkg::WORD_STRIDE);
    wire [11:0] base_adr = 12'(dual_alu_pkg::BASE_OFFSET + u * dual_alu_pkg::CIRC_STRIDE);
    wire [11:0] len_adr  = 12'(dual_alu_pkg::LEN_OFFSET  + u * dual_alu_pkg::CIRC_STRIDE);
    wire [11:0] gpr_adr  = 12'(dual_alu_pkg::GPR_OFFSET  + u * dual_alu_pkg::GPR_STRIDE);

    // Address decode
    wire       hit_cmd  = word_adr == cmd_adr;
    wire       hit_imm  = word_adr == imm_adr;
    wire       hit_stat = word_adr == stat_adr;
    wire       hit_jump = word_adr == jump_adr;
    wire       hit_last = word_adr == last_adr;
    wire       hit_base = {wb_adr_i[11:4], 4'h0} == base_adr;
    wire       hit_len  = {wb_adr_i[11:4], 4'h0} == len_adr;
    wire       hit_gpr  = {wb_adr_i[11:7], 7'h00} == gpr_adr;
    wire [1:0] circ_sel = wb_adr_i[3:2];
    wire [4:0] gpr_sel  = wb_adr_i[6:2];

    // Command fields, taken straight from the write data
    wire [3:0] op_field  = wb_dat_i[dual_alu_pkg::CMD_OP_LSB +: 4];
    wire [4:0] src_a     = wb_dat_i[dual_alu_pkg::CMD_A_LSB +: 5];
    wire [4:0] src_b     = wb_dat_i[dual_alu_pkg::CMD_B_LSB +: 5];
    wire [4:0] dst       = wb_dat_i[dual_alu_pkg::CMD_DST_LSB +: 5];
    wire       use_imm   = wb_dat_i[dual_alu_pkg::CMD_USE_IMM];
    wire       imm_short = wb_dat_i[dual_alu_pkg::CMD_IMM8];
    wire       hold      = wb_dat_i[dual_alu_pkg::CMD_HOLD];
    wire       unsig     = wb_dat_i[dual_alu_pkg::CMD_UNSIGNED];
    wire       alt_dst   = wb_dat_i[dual_alu_pkg::CMD_ALT_DST];
    // A two-bit option field can name only one option at a time
    wire dual_alu_pkg::option_type opt = dual_alu_pkg::option_type'(wb_dat_i[dual_alu_pkg::CMD_OPT_LSB +: 2]); // [RULE6]
    wire dual_alu_pkg::op_type     op  = dual_alu_pkg::op_type'(op_field);

    // Operand fetch; an 8-bit immediate is sign extended to a full word
    wire [31:0] imm_ext   = imm_short ? {{24{imm_value[7]}}, imm_value[7:0]} : imm_value; // [RULE18]
    wire [31:0] operand_a = gpr[src_a];
    wire [31:0] operand_b = use_imm ? imm_ext : gpr[src_b];             // [RULE2]

    // Legality checks
    wire is_plain_addsub = (op == dual_alu_pkg::OP_ADD) | (op == dual_alu_pkg::OP_SUB);
    wire bad_unknown     = op_field > dual_alu_pkg::OP_LAST;
    wire bad_circ_idx    = (opt == dual_alu_pkg::OPT_CIRC) & (src_a > dual_alu_pkg::CIRC_IDX_MAX); // [RULE4]
    wire bad_option      = ((opt != dual_alu_pkg::OPT_NONE) | alt_dst) & ~is_plain_addsub |
                           alt_dst & (opt != dual_alu_pkg::OPT_NONE);
    wire cmd_hit         = write_take & hit_cmd & full_word;
    wire cmd_reject      = cmd_hit & (bad_unknown | bad_circ_idx | bad_option);
    wire cmd_accept      = cmd_hit & ~cmd_reject;
    wire [1:0] next_cause = bad_unknown  ? dual_alu_pkg::CAUSE_UNKNOWN :
                            bad_circ_idx ? dual_alu_pkg::CAUSE_CIRC_IDX : dual_alu_pkg::CAUSE_OPTION;

    // Bus writes to storage, with byte enables
    wire stat_write = write_take & hit_stat;
    wire imm_write  = write_take & hit_imm;
    wire base_write = write_take & hit_base;
    wire len_write  = write_take & hit_len;
    wire gpr_write  = write_take & hit_gpr;

    // Arithmetic core for this unit
    logic [31:0] core_result;
    logic [3:0]  core_flags;
    logic        core_writes;

    int_arith_core u_int_arith_core (
      .op_code     (op),
      .option_sel  (opt),
      .unsigned_cmp(unsig),
      .operand_a   (operand_a),
      .operand_b   (operand_b),
      .carry_in    (integer_status_reg[dual_alu_pkg::FLAG_CARRY]), // [RULE10]
      .circ_base   (circ_base_regs[src_a[1:0]]),
      .circ_length (circ_length_regs[src_a[1:0]]),
      .result      (core_result),
      .flags       (core_flags),
      .writes_dest (core_writes)
    );

    wire write_dest = cmd_accept & core_writes;                         // [RULE18]

    // Register file, circular registers and command-side results
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        for (int i = 0; i < dual_alu_pkg::GPR_COUNT; i++) begin
          gpr[i] <= dual_alu_pkg::RESET_WORD;
        end
        for (int i = 0; i < dual_alu_pkg::CIRC_COUNT; i++) begin
          circ_base_regs[i]   <= dual_alu_pkg::RESET_WORD;
          circ_length_regs[i] <= dual_alu_pkg::RESET_WORD;
        end
        computed_jump_reg <= dual_alu_pkg::RESET_WORD;
        last_result       <= dual_alu_pkg::RESET_WORD;
      end else begin
        if (write_dest & alt_dst & dst[2]) begin
          circ_length_regs[dst[1:0]] <= core_result;                  // [RULE7]
        end else if (write_dest & alt_dst) begin
          circ_base_regs[dst[1:0]] <= core_result;                    // [RULE7]
        end else if (write_dest) begin
          gpr[dst] <= core_result;                                    // [RULE2]
        end
        if (write_dest & (opt == dual_alu_pkg::OPT_JUMP)) begin
          computed_jump_reg <= core_result;                           // [RULE3]
        end
        if (write_dest) begin
          last_result <= core_result;
        end
        if (gpr_write) begin
          gpr[gpr_sel] <= dual_alu_pkg::merge_bytes(gpr[gpr_sel], wb_dat_i, wb_sel_i);
        end
        if (base_write) begin
          circ_base_regs[circ_sel] <= dual_alu_pkg::merge_bytes(circ_base_regs[circ_sel], wb_dat_i, wb_sel_i);
        end
        if (len_write) begin
          circ_length_regs[circ_sel] <= dual_alu_pkg::merge_bytes(circ_length_regs[circ_sel], wb_dat_i, wb_sel_i);
        end
      end
    end

    // Immediate and the last command word
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        imm_value <= dual_alu_pkg::RESET_WORD;
        cmd_word  <= dual_alu_pkg::RESET_WORD;
      end else begin
        if (imm_write) begin
          imm_value <= dual_alu_pkg::merge_bytes(imm_value, wb_dat_i, wb_sel_i);
        end
        if (cmd_hit) begin
          cmd_word <= wb_dat_i;
        end
      end
    end

    // Flags: a held command leaves them alone; a bus write may restore them
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        integer_status_reg <= dual_alu_pkg::RESET_FLAGS;
      end else if (cmd_accept & ~hold) begin
        integer_status_reg <= core_flags;                             // [RULE9] [RULE17]
      end else if (stat_write & wb_sel_i[0]) begin
        integer_status_reg <= wb_dat_i[3:0];
      end
    end

    // Rejection is sticky; a new rejection wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        reject_flag  <= 1'b0;
        reject_cause <= 2'h0;
      end else if (cmd_reject) begin
        reject_flag  <= 1'b1;                                         // [RULE4]
        reject_cause <= next_cause;
      end else if (stat_write & wb_sel_i[0] & wb_dat_i[dual_alu_pkg::STAT_REJECT]) begin
        reject_flag  <= 1'b0;
        reject_cause <= 2'h0;
      end
    end

    // Read mux; zero when this unit owns none of the address
    wire [31:0] stat_word = {25'h000_0000, reject_cause, reject_flag, integer_status_reg};
    assign unit_rdata[u] = hit_cmd  ? cmd_word :
                           hit_imm  ? imm_value :
                           hit_stat ? stat_word :
                           hit_jump ? computed_jump_reg :
                           hit_last ? last_result :
                           hit_base ? circ_base_regs[circ_sel] :
                           hit_len  ? circ_length_regs[circ_sel] :
                           hit_gpr  ? gpr[gpr_sel] : 32'h0000_0000;
  end

endmodule

`default_nettype wire

// [dv/alu_bus_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module alu_bus_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  // ------------
  // Bus answers
  // ------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Request seen and not yet answered
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd   = take && !wb_we_i;
  a_ack_follows_take: assert property (take |=> wb_ack_o) else $error("request not answered");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_idle_after_reset: assert property ($rose(reset_n) |-> !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("bus not idle after reset");
  a_read_data_holds: assert property (!rd |=> $stable(wb_dat_o)) else $error("read data moved without read");
  a_unmapped_zero: assert property (rd && wb_adr_i[11:8] inside {4'h1, 4'h2, 4'h3} |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_status_narrow: assert property (rd && wb_adr_i[11:3] == 9'h004 |=> wb_dat_o[31:7] == 25'h000_0000)
    else $error("status upper bits set");
  // Wide status bits would mean flags leaking between units
  c_write: cover property (take && wb_we_i);
  c_read: cover property (rd);
  c_status_read: cover property (rd && wb_adr_i[11:3] == 9'h004);
endmodule
bind dual_integer_alu_arith alu_bus_checker u_alu_bus_checker (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [dv/wb_issuer.sv]
`timescale 1ns/1ps
`default_nettype none
module wb_issuer (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [11:0]      adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  logic hung;
  // ------------
  // Issuer side
  // ------------
  // Idle bus from time zero
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    hung = 1'b0;
  end
  // Held whole until ack is sampled; released data is inverted so no stale word lingers
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    hung = (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we, wdat} <= {3'b000, ~d};
  endtask
endmodule
`default_nettype wire

// [dv/test_dual_integer_alu_arith.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dual_integer_alu_arith;
  logic        clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] q;
  int          n_fail;
  int          compares;
  // ------------
  // Structure
  // ------------
  dual_integer_alu_arith u_dual_integer_alu_arith (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  wb_issuer u_wb_issuer (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .wdat(wdat));
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hung bus ends the run at once rather than stalling every later check
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_wb_issuer.xfer(w, a, d, q);
    if (u_wb_issuer.hung) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic c(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    compares++;
    if (q !== e) begin
      n_fail++;
      $display("[ERR] t=%0t adr=%h got=%h exp=%h", $time, a, q, e);
    end
  endtask
  // First unit: issue, then read destination and status
  task automatic run(input logic [3:0] op, input logic [4:0] a, input logic [4:0] b, input logic [4:0] d,
                     input logic [6:0] f, input logic [31:0] r, input logic [6:0] z);
    bus(1'b1, 12'h000, {6'h00, f, d, b, a, op});  // Single option code
    c(12'h400 + {5'h00, d, 2'b00}, r);
    c(12'h020, {25'h000_0000, z});
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_add();
    bus(1'b1, 12'h404, 32'h7FFF_FFFF);
    bus(1'b1, 12'h408, 32'h0000_0001);
    run(4'h0, 5'h01, 5'h02, 5'h03, 7'h00, 32'h8000_0000, 7'h06);
    bus(1'b1, 12'h004, 32'h0000_C410);  // Same add on the second unit
    c(12'h024, 32'h0000_0001);
    c(12'h020, 32'h0000_0006);
    bus(1'b1, 12'h010, 32'h0000_00FF);
    run(4'h0, 5'h02, 5'h00, 5'h04, 7'h03, 32'h0000_0000, 7'h09);
    c(12'h200, 32'h0000_0000);
  endtask
  task automatic t_carry_half();
    run(4'h2, 5'h01, 5'h02, 5'h05, 7'h00, 32'h8000_0001, 7'h06);
    run(4'h3, 5'h02, 5'h02, 5'h06, 7'h00, 32'hFFFF_FFFF, 7'h02);
    bus(1'b1, 12'h41C, 32'hFFFF_FFFF);
    bus(1'b1, 12'h420, 32'h0000_0002);
    run(4'h5, 5'h07, 5'h08, 5'h09, 7'h00, 32'hFFFF_FFFE, 7'h02);
    run(4'h4, 5'h01, 5'h02, 5'h0A, 7'h00, 32'h4000_0000, 7'h00);
  endtask
  task automatic t_compare();
    run(4'h6, 5'h07, 5'h08, 5'h0B, 7'h00, 32'h0000_0000, 7'h02);
    run(4'h6, 5'h07, 5'h08, 5'h0B, 7'h20, 32'h0000_0000, 7'h00);
    run(4'h6, 5'h08, 5'h08, 5'h0B, 7'h00, 32'h0000_0000, 7'h01);
    run(4'h7, 5'h07, 5'h08, 5'h0C, 7'h00, 32'h0000_0002, 7'h00);
    run(4'h8, 5'h07, 5'h08, 5'h0D, 7'h00, 32'hFFFF_FFFF, 7'h02);
  endtask
  task automatic t_abs_options();
    run(4'h9, 5'h03, 5'h00, 5'h0E, 7'h00, 32'h7FFF_FFFF, 7'h06);
    run(4'h9, 5'h07, 5'h00, 5'h0E, 7'h00, 32'h0000_0001, 7'h02);
    run(4'h0, 5'h01, 5'h02, 5'h0F, 7'h10, 32'h8000_0000, 7'h02);
    run(4'h1, 5'h02, 5'h00, 5'h10, 7'h04, 32'h0000_0001, 7'h08);
    c(12'h030, 32'h0000_0001);
    run(4'h0, 5'h03, 5'h03, 5'h11, 7'h0C, 32'h4000_0000, 7'h00);
  endtask
  // Base and length loaded by the alternative add, then wrap and a refused index
  task automatic t_circ();
    bus(1'b1, 12'h010, 32'h0000_0100);
    bus(1'b1, 12'h000, 32'h0208_0000);
    bus(1'b1, 12'h010, 32'h0000_0010);
    bus(1'b1, 12'h000, 32'h0209_0000);
    c(12'h040, 32'h0000_0100);
    c(12'h080, 32'h0000_0010);
    bus(1'b1, 12'h400, 32'h0000_010C);
    bus(1'b1, 12'h010, 32'h0000_0008);
    run(4'h0, 5'h00, 5'h00, 5'h12, 7'h09, 32'h0000_0104, 7'h00);
    run(4'h0, 5'h04, 5'h02, 5'h13, 7'h08, 32'h0000_0000, 7'h30);
    bus(1'b1, 12'h020, 32'h0000_0015);  // Restore flags, clear reject
    c(12'h020, 32'h0000_0005);
    bus(1'b1, 12'h000, 32'h0020_0007);  // Jump option on max is refused
    c(12'h020, 32'h0000_0055);
    bus(1'b1, 12'h000, 32'h0000_000F);  // Unknown operation is refused
    c(12'h020, 32'h0000_0075);
    c(12'h038, 32'h0000_0104);  // Refused commands leave the last result
  endtask
  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset held 20 cycles, then the scenarios in order
  initial begin
    n_fail = 0;
    compares = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_add();
    t_carry_half();
    t_compare();
    t_abs_options();
    t_circ();
    conclude();
  end
endmodule
`default_nettype wire
